//--- sfd_pkg.sv
// package and port-width lane strobe decoder for the dram controller
`default_nettype none
package sfd_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_OFS   = 8'h00;
    localparam logic [7:0] ADDR_OFS  = 8'h04;
    localparam logic [7:0] WDATA_OFS = 8'h08;
    localparam logic [7:0] CMD_OFS   = 8'h0c;
    localparam logic [7:0] STAT_OFS  = 8'h10;
    localparam logic [7:0] RDATA_OFS = 8'h14;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // config fields
    localparam int CFG_FP_BIT    = 0;
    localparam int CFG_PORT_LSB  = 1;
    localparam int CFG_CL3_BIT   = 3;
    localparam int CFG_RLEN_LSB  = 4;
    localparam int CFG_WAIT_LSB  = 6;
    localparam int CFG_BBW_LSB   = 10;
    localparam int CFG_DMA_BIT   = 14;
    // command fields
    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_BURST_BIT = 2;
    // memory address layout
    localparam int MA_W          = 13;
    localparam int ROW_LSB       = 12;
    localparam int COL_LSB       = 2;
    localparam int PRE_ALL_BIT   = 10;
    // sequence counts in clock cycles
    localparam logic [1:0] LAST_BEAT     = 2'h3;
    localparam logic [3:0] DMA_SWITCH    = 4'hd;
    localparam logic [3:0] NOP_ONE_CL3   = 4'h2;
    localparam logic [3:0] NOP_BURST_CL3 = 4'h5;
    localparam logic [3:0] NOP_ONE_CL2   = 4'h1;
    localparam logic [3:0] NOP_BURST_CL2 = 4'h4;
    localparam logic [3:0] INH_CL3       = 4'h3;
    localparam logic [3:0] INH_CL2       = 4'h1;
    // sdram commands as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] SD_INHIBIT = 4'hf;
    localparam logic [3:0] SD_NOP     = 4'h7;
    localparam logic [3:0] SD_ACT     = 4'h3;
    localparam logic [3:0] SD_READ    = 4'h5;
    localparam logic [3:0] SD_WRITE   = 4'h4;
    localparam logic [3:0] SD_BST     = 4'h6;
    localparam logic [3:0] SD_PRE     = 4'h2;
    localparam logic [3:0] SD_REF     = 4'h1;
    localparam logic [3:0] SD_LMR     = 4'h0;

    typedef enum logic [1:0] {
        OP_READ    = 2'h0,
        OP_WRITE   = 2'h1,
        OP_LOAD    = 2'h2,
        OP_REFRESH = 2'h3
    } sfd_op_t;

    typedef enum logic [1:0] {
        PORT_32 = 2'h0,
        PORT_8  = 2'h1,
        PORT_16 = 2'h2
    } sfd_port_t;

    typedef struct packed {
        logic [3:0]      sdCmd;
        logic            rasN;
        logic [3:0]      casN;
        logic [3:0]      byteLaneStrobeN;
        logic            addressMuxSelect;
        logic [MA_W-1:0] memAddr;
        logic [31:0]     dataOut;
        logic            dataOe;
    } sfd_pins_t;

    localparam sfd_pins_t PINS_IDLE = '{SD_INHIBIT, 1'b1, 4'hf, 4'hf, 1'b0,
                                        {MA_W{1'b0}}, 32'h0000_0000, 1'b0};
endpackage

module sfd_lane_decode
    import sfd_pkg::*;
(
    // port width in, active-low lane mask out
    input  wire logic [1:0] portSize,
    output logic      [3:0] laneN
);
    // lane 3 always, lane 2 from 16 bits up, lanes 1..0 only at 32 bits
    genvar i;
    for (i = 0; i < 4; i = i + 1) begin : g_lane
        if (i == 3) begin : g_top
            assign laneN[i] = 1'b0;
        end else if (i == 2) begin : g_mid
            assign laneN[i] = (portSize == PORT_8);
        end else begin : g_low
            assign laneN[i] = (portSize != PORT_32);
        end
    end
endmodule
`default_nettype wire

//--- sfd_dram_ctrl.sv
// sdram and fast page dram controller with ahb-lite register slave
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`default_nettype none
module sfd_dram_ctrl
    import sfd_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // memory pins
    output sfd_pins_t        memPins,
    input  wire logic [31:0] dataIn
);
    typedef enum logic [13:0] {
        ST_IDLE = 14'h0001, ST_PRE  = 14'h0002, ST_ACT  = 14'h0004, ST_SRD  = 14'h0008,
        ST_NOP  = 14'h0010, ST_BST  = 14'h0020, ST_INH  = 14'h0040, ST_SWR  = 14'h0080,
        ST_SCMD = 14'h0100, ST_FRAS = 14'h0200, ST_FCAS = 14'h0400, ST_FGAP = 14'h0800,
        ST_FREF = 14'h1000, ST_DMA  = 14'h2000
    } sfd_state_t;

    sfd_state_t      stReg, stNext;
    logic [31:0]     cfgReg, addrReg, wdataReg, rdataReg;
    logic [2:0]      cmdReg;
    logic [3:0]      cntReg, cntNext;
    logic [1:0]      beatReg, beatNext;
    logic            rowOpenReg;
    logic [MA_W-1:0] openRowReg;
    logic [2:0]      capReg;
    logic            capNext;
    logic [31:0]     dIn1Reg, dIn2Reg;
    logic            wrPendReg, rdPendReg, goReg;
    logic [7:0]      dAddrReg;
    sfd_pins_t       pinsNext;
    logic [3:0]      laneMask;

    // decoded configuration
    wire             isFp     = cfgReg[CFG_FP_BIT];
    wire [1:0]       portSz   = cfgReg[CFG_PORT_LSB +: 2];
    wire             cl3      = cfgReg[CFG_CL3_BIT];
    wire [1:0]       refLen   = cfgReg[CFG_RLEN_LSB +: 2];
    wire [3:0]       firstWt  = cfgReg[CFG_WAIT_LSB +: 4];
    wire [3:0]       beatWt   = cfgReg[CFG_BBW_LSB +: 4];
    wire             nextDma  = cfgReg[CFG_DMA_BIT];
    wire [1:0]       op       = cmdReg[CMD_OP_LSB +: 2];
    wire             burst    = cmdReg[CMD_BURST_BIT];
    wire             isRw     = (op == OP_READ) || (op == OP_WRITE);
    wire [MA_W-1:0]  rowAddr  = addrReg[ROW_LSB +: MA_W];
    wire [MA_W-1:0]  colAddr  = {3'h0, addrReg[COL_LSB +: 10]} + {11'h0, beatReg};
    wire             rowHit   = rowOpenReg && (openRowReg == rowAddr);
    wire             lastBeat = !burst || (beatReg == LAST_BEAT);
    wire             busy     = (stReg != ST_IDLE) || (capReg != 3'h0) || goReg;
    wire [3:0]       nopCnt   = cl3 ? (burst ? NOP_BURST_CL3 : NOP_ONE_CL3)
                                    : (burst ? NOP_BURST_CL2 : NOP_ONE_CL2);
    wire [3:0]       inhCnt   = cl3 ? INH_CL3 : INH_CL2;
    wire [3:0]       refCnt   = {2'h0, refLen} + 4'h1;

    // ahb decode
    wire             aPhase   = hsel && htrans[1] && hready;
    wire             cmdWr    = wrPendReg && (dAddrReg == CMD_OFS);
    wire             start    = goReg;
    wire [31:0]      rdMux    = (dAddrReg == CFG_OFS)   ? cfgReg :
                                (dAddrReg == ADDR_OFS)  ? addrReg :
                                (dAddrReg == WDATA_OFS) ? wdataReg :
                                (dAddrReg == CMD_OFS)   ? {29'h0, cmdReg} :
                                (dAddrReg == STAT_OFS)  ? {29'h0, rowOpenReg, isFp, busy} :
                                (dAddrReg == RDATA_OFS) ? rdataReg : 32'h0000_0000;

    sfd_lane_decode u_lane (
        .portSize (portSz),
        .laneN    (laneMask)
    );

    always_comb begin
        stNext   = stReg;
        cntNext  = cntReg;
        beatNext = beatReg;
        capNext  = 1'b0;
        pinsNext = PINS_IDLE;
        case (stReg)
            ST_IDLE: begin
                beatNext = 2'h0;
                if (start && isFp) begin
                    if (op == OP_REFRESH) begin
                        stNext  = ST_FREF;
                        cntNext = refCnt;
                    end else if (isRw) begin
                        stNext = ST_FRAS;
                    end
                end else if (start) begin
                    if (isRw && rowHit) begin
                        stNext = (op == OP_READ) ? ST_SRD : ST_SWR;
                    end else if (rowOpenReg) begin
                        stNext = ST_PRE;
                    end else begin
                        stNext = isRw ? ST_ACT : ST_SCMD;
                    end
                end
            end
            ST_PRE: begin
                pinsNext.sdCmd = SD_PRE;
                pinsNext.memAddr[PRE_ALL_BIT] = 1'b1;
                stNext = isRw ? ST_ACT : ST_SCMD;
            end
            ST_ACT: begin
                pinsNext.sdCmd   = SD_ACT;
                pinsNext.memAddr = rowAddr;
                stNext = (op == OP_READ) ? ST_SRD : ST_SWR;
            end
            ST_SRD: begin
                pinsNext.sdCmd            = SD_READ;
                pinsNext.memAddr          = colAddr;
                pinsNext.addressMuxSelect = 1'b1;
                pinsNext.byteLaneStrobeN  = laneMask;
                cntNext = nopCnt - 4'h1;
                stNext  = ST_NOP;
            end
            ST_NOP: begin
                pinsNext.sdCmd           = SD_NOP;
                pinsNext.byteLaneStrobeN = laneMask;
                cntNext = cntReg - 4'h1;
                if (cntReg == 4'h0) begin
                    stNext = ST_BST;
                end
            end
            ST_BST: begin
                pinsNext.sdCmd = SD_BST;
                capNext = 1'b1;
                cntNext = inhCnt - 4'h1;
                stNext  = ST_INH;
            end
            ST_INH: begin
                cntNext = cntReg - 4'h1;
                if (cntReg == 4'h0) begin
                    stNext = ST_IDLE;
                end
            end
            ST_SWR: begin
                pinsNext.sdCmd            = (beatReg == 2'h0) ? SD_WRITE : SD_NOP;
                pinsNext.memAddr          = colAddr;
                pinsNext.addressMuxSelect = 1'b1;
                pinsNext.byteLaneStrobeN  = laneMask;
                pinsNext.dataOut          = wdataReg;
                pinsNext.dataOe           = 1'b1;
                beatNext = beatReg + 2'h1;
                if (lastBeat) begin
                    stNext = ST_IDLE;
                end
            end
            ST_SCMD: begin
                pinsNext.sdCmd   = (op == OP_LOAD) ? SD_LMR : SD_REF;
                pinsNext.memAddr = addrReg[MA_W-1:0];
                cntNext = inhCnt - 4'h1;
                stNext  = ST_INH;
            end
            ST_FRAS: begin
                pinsNext.rasN    = 1'b0;
                pinsNext.memAddr = rowAddr;
                cntNext = firstWt;
                stNext  = ST_FCAS;
            end
            ST_FCAS: begin
                pinsNext.rasN             = 1'b0;
                pinsNext.casN             = laneMask;
                pinsNext.byteLaneStrobeN  = laneMask;
                pinsNext.memAddr          = colAddr;
                pinsNext.addressMuxSelect = 1'b1;
                pinsNext.dataOut          = wdataReg;
                pinsNext.dataOe           = (op == OP_WRITE);
                cntNext = cntReg - 4'h1;
                if (cntReg == 4'h0) begin
                    capNext = (op == OP_READ);
                    if (lastBeat && nextDma) begin
                        stNext  = ST_DMA;
                        cntNext = DMA_SWITCH - 4'h1;
                    end else begin
                        stNext = lastBeat ? ST_IDLE : ST_FGAP;
                    end
                end
            end
            ST_FGAP: begin
                pinsNext.rasN             = 1'b0;
                pinsNext.memAddr          = colAddr;
                pinsNext.addressMuxSelect = 1'b1;
                beatNext = beatReg + 2'h1;
                cntNext  = beatWt;
                stNext   = ST_FCAS;
            end
            ST_FREF: begin
                pinsNext.casN = 4'h0;
                pinsNext.rasN = (cntReg == refCnt);
                cntNext = cntReg - 4'h1;
                if (cntReg == 4'h0) begin
                    stNext = ST_IDLE;
                end
            end
            ST_DMA: begin
                cntNext = cntReg - 4'h1;
                if (cntReg == 4'h0) begin
                    stNext = ST_IDLE;
                end
            end
            default: begin
                stNext = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stReg   <= ST_IDLE;
            cntReg  <= 4'h0;
            beatReg <= 2'h0;
            memPins <= PINS_IDLE;
            capReg  <= 3'h0;
        end else begin
            stReg   <= stNext;
            cntReg  <= cntNext;
            beatReg <= beatNext;
            memPins <= pinsNext;
            capReg  <= {capReg[1:0], capNext};
        end
    end

    // open row tracking
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rowOpenReg <= 1'b0;
            openRowReg <= {MA_W{1'b0}};
        end else if (stReg == ST_PRE) begin
            rowOpenReg <= 1'b0;
        end else if (stReg == ST_ACT) begin
            rowOpenReg <= 1'b1;
            openRowReg <= rowAddr;
        end
    end

    // read data: two-stage pin synchroniser, then capture
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dIn1Reg  <= 32'h0000_0000;
            dIn2Reg  <= 32'h0000_0000;
            rdataReg <= 32'h0000_0000;
        end else begin
            dIn1Reg <= dataIn;
            dIn2Reg <= dIn1Reg;
            if (capReg[2]) begin
                rdataReg <= dIn2Reg;
            end
        end
    end

    // ahb-lite slave: writes zero wait, reads one wait state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPendReg <= 1'b0;
            rdPendReg <= 1'b0;
            dAddrReg  <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            if (hready) begin
                wrPendReg <= aPhase && hwrite;
                rdPendReg <= aPhase && !hwrite;
                dAddrReg  <= aPhase ? {haddr[7:2], 2'h0} : dAddrReg;
                hreadyout <= !(aPhase && !hwrite);
            end else if (rdPendReg) begin
                rdPendReg <= 1'b0;
                hrdata    <= rdMux;
                hreadyout <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfgReg   <= CFG_RESET;
            addrReg  <= 32'h0000_0000;
            wdataReg <= 32'h0000_0000;
            cmdReg   <= 3'h0;
        end else if (wrPendReg && !busy) begin
            if (dAddrReg == CFG_OFS)   cfgReg   <= hwdata;
            if (dAddrReg == ADDR_OFS)  addrReg  <= hwdata;
            if (dAddrReg == WDATA_OFS) wdataReg <= hwdata;
            if (dAddrReg == CMD_OFS)   cmdReg   <= hwdata[2:0];
        end
    end

    // command word lands first, sequencer starts a cycle later on the new op
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            goReg <= 1'b0;
        end else begin
            goReg <= cmdWr && !busy;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [4:0] dmaCycReg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dmaCycReg <= 5'h00;
        end else begin
            dmaCycReg <= (stReg == ST_DMA) ? dmaCycReg + 5'h01 : 5'h00;
        end
    end

    sequence nops2_s; (stReg == ST_NOP) [*2]; endsequence
    sequence nops5_s; (stReg == ST_NOP) [*5]; endsequence

    lane_strobe_a: assert property (stReg == ST_SRD |=> memPins.byteLaneStrobeN ==
        ((portSz == PORT_8) ? 4'h7 : (portSz == PORT_16) ? 4'h3 : 4'h0))
        else $error("lane strobes wrong for port width");
    fp_cas_width_a: assert property (stReg == ST_FCAS |=> memPins.casN ==
        ((portSz == PORT_8) ? 4'h7 : (portSz == PORT_16) ? 4'h3 : 4'h0))
        else $error("column strobes wrong for port width");
    row_hit_skip_a: assert property ((stReg == ST_IDLE) && start && !isFp && isRw && rowHit
        |=> (stReg == ST_SRD) || (stReg == ST_SWR))
        else $error("precharge or activate on row hit");
    single_nop_a: assert property ((stReg == ST_SRD) && cl3 && !burst
        |=> nops2_s ##1 (stReg == ST_BST))
        else $error("single read nop count wrong");
    burst_nop_a: assert property ((stReg == ST_SRD) && cl3 && burst
        |=> nops5_s ##1 (stReg == ST_BST))
        else $error("burst read nop count wrong");
    bst_inhibit_a: assert property ((stReg == ST_BST) && cl3 && (op == OP_READ)
        |=> (stReg == ST_INH) [*3] ##1 (stReg == ST_IDLE) ##1 (memPins.sdCmd == SD_INHIBIT))
        else $error("inhibit spacing after terminate wrong");
    dma_gap_a: assert property ($fell(stReg == ST_DMA) |-> $past(dmaCycReg) == 5'h0c)
        else $error("dma switch gap not thirteen cycles");
    write_col_a: assert property (stReg == ST_SWR |=> memPins.addressMuxSelect
        && memPins.dataOe && (memPins.memAddr == $past(colAddr)))
        else $error("write cycle without column address");
    fp_refresh_a: assert property ($rose(stReg == ST_FREF) |->
        ##(1) (stReg == ST_FREF) [*1] ##0 (cntReg == refCnt - 4'h1))
        else $error("refresh length not from field");
    load_mode_a: assert property ((stReg == ST_SCMD) && (op == OP_LOAD)
        |=> memPins.sdCmd == SD_LMR)
        else $error("load mode command missing");
    act_row_a: assert property (stReg == ST_ACT |=> !memPins.addressMuxSelect
        && (memPins.memAddr == $past(rowAddr)))
        else $error("activate without row address");
    bus_release_a: assert property ((stReg == ST_SWR) && lastBeat ##1 (stReg != ST_SWR)
        |=> !memPins.dataOe)
        else $error("data bus not released after write");
endmodule
`default_nettype wire

//--- sfd_mem_model.sv
// behavioural sdram and fast page memory answering the controller's pins
`default_nettype none
module sfd_mem_model
    import sfd_pkg::*;
#(
    parameter int CAS_LAT = 3
)(
    // clock and controller pins
    input  wire logic      core_clk,
    input  wire sfd_pins_t memPins,
    // read data toward the controller
    output logic [31:0]    dataIn
);
    timeunit 1ns;
    timeprecision 1ns;
    int          rdAge   = -1;
    int          bstAge  = -1;
    logic        sdDrive = 1'b0;
    logic [31:0] word    = 32'h0;
    logic [31:0] lastOut = 32'h0;
    wire logic   fpDrive = !memPins.rasN && memPins.casN != 4'hf && !memPins.dataOe;
    // released bus toggles each cycle so stale data never passes
    assign dataIn = fpDrive ? {16'h5a3c, 3'h0, memPins.memAddr} : sdDrive ? word : ~lastOut;
    always @(posedge core_clk) begin
        lastOut <= dataIn;
        if (memPins.sdCmd == SD_READ) begin
            rdAge = 0;
            bstAge = -1;
            word <= {16'h5a3c, 3'h0, memPins.memAddr};
        end else if (rdAge >= 0) begin
            rdAge++;
        end
        if (memPins.sdCmd == SD_BST) bstAge = 0;
        else if (bstAge >= 0) bstAge++;
        // data from cas latency after read until the terminate takes effect
        sdDrive <= rdAge >= CAS_LAT - 1 && bstAge <= CAS_LAT - 2;
    end
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the dram controller over ahb-lite
`default_nettype none
module testbench;
    import sfd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    sfd_pins_t   memPins;
    logic [31:0] dataIn;
    logic        logOn;
    sfd_pins_t   trace[$];
    int          failCount = 0;
    int          comparisons = 0;

    sfd_dram_ctrl dut_u (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .memPins(memPins),
        .dataIn(dataIn));
    sfd_mem_model mem_u (.core_clk(core_clk), .memPins(memPins), .dataIn(dataIn));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (logOn) trace.push_back(memPins);

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        q = hrdata;
    endtask
    function automatic logic [31:0] cfgOf(input logic fp, input logic [1:0] port,
                                          input logic [3:0] fw, input logic [3:0] bw);
        cfgOf = 32'h0;
        cfgOf[CFG_FP_BIT] = fp;
        cfgOf[CFG_PORT_LSB +: 2] = port;
        cfgOf[CFG_CL3_BIT] = 1'b1;
        cfgOf[CFG_WAIT_LSB +: 4] = fw;
        cfgOf[CFG_BBW_LSB +: 4] = bw;
    endfunction
    // start one operation and record the pins until busy clears
    task automatic runOp(input logic [31:0] cfg, input logic [31:0] addr, input logic [2:0] cmd);
        logic [31:0] s;
        bus(1'b1, CFG_OFS, cfg, s);
        bus(1'b1, ADDR_OFS, addr, s);
        trace.delete();
        logOn = 1'b1;
        bus(1'b1, CMD_OFS, {29'h0, cmd}, s);
        s = 32'h1;
        for (int i = 0; i < 60 && s[0] !== 1'b0; i++) bus(1'b0, STAT_OFS, 32'h0, s);
        chk(s[0], 1'b0);
        logOn = 1'b0;
    endtask
    function automatic int findCmd(input logic [3:0] c);
        findCmd = -1;
        foreach (trace[i]) if (trace[i].sdCmd == c && findCmd < 0) findCmd = i;
    endfunction
    function automatic logic [3:0] firstCmd();
        foreach (trace[i]) if (trace[i].sdCmd != SD_INHIBIT) return trace[i].sdCmd;
        return SD_INHIBIT;
    endfunction
    function automatic int nopRun(input int from);
        nopRun = 0;
        while (from + 1 + nopRun < trace.size() && trace[from + 1 + nopRun].sdCmd == SD_NOP)
            nopRun++;
    endfunction
    function automatic int cntCas(input logic [3:0] v);
        cntCas = 0;
        foreach (trace[i]) if (trace[i].casN == v) cntCas++;
    endfunction

    task automatic testReset();
        logic [31:0] q;
        chk(memPins, PINS_IDLE);
        bus(1'b0, CFG_OFS, 32'h0, q);
        chk(q, CFG_RESET);
        bus(1'b1, ADDR_OFS, 32'h0123_4567, q);
        bus(1'b0, ADDR_OFS, 32'h0, q);
        chk(q, 32'h0123_4567);
        bus(1'b0, 8'h40, 32'h0, q);
        chk({q, 31'h0, hresp}, 64'h0);
        $display("test reset done");
    endtask
    task automatic testSdRead();
        int a;
        int r;
        int b;
        logic [31:0] q;
        runOp(cfgOf(1'b0, PORT_8, 4'h0, 4'h0), 32'h0000_500c, {1'b0, OP_READ});
        a = findCmd(SD_ACT);
        r = findCmd(SD_READ);
        chk(findCmd(SD_PRE), -1);
        chk({trace[a].addressMuxSelect, trace[a].memAddr}, {1'b0, 13'h5});
        chk({trace[r].addressMuxSelect, trace[r].memAddr}, {1'b1, 13'h3});
        chk(trace[r].byteLaneStrobeN, 4'h7);
        chk(nopRun(r), 2);
        b = findCmd(SD_BST);
        chk({trace[b + 1].sdCmd, trace[b + 2].sdCmd, trace[b + 3].sdCmd}, {3{SD_INHIBIT}});
        bus(1'b0, RDATA_OFS, 32'h0, q);
        chk(q, 32'h5a3c_0003);
        runOp(cfgOf(1'b0, PORT_16, 4'h0, 4'h0), 32'h0000_5020, {1'b1, OP_READ});
        r = findCmd(SD_READ);
        chk(firstCmd(), SD_READ);
        chk(trace[r].byteLaneStrobeN, 4'h3);
        chk(nopRun(r), 5);
        $display("test sdram read done");
    endtask
    task automatic testSdWrite();
        int w;
        logic [31:0] q;
        bus(1'b1, WDATA_OFS, 32'h1234_abcd, q);
        runOp(cfgOf(1'b0, PORT_32, 4'h0, 4'h0), 32'h0000_9010, {1'b0, OP_WRITE});
        w = findCmd(SD_WRITE);
        chk(firstCmd(), SD_PRE);
        chk({trace[w].addressMuxSelect, trace[w].dataOe, trace[w].dataOut},
            {1'b1, 1'b1, 32'h1234_abcd});
        chk(trace[w].byteLaneStrobeN, 4'h0);
        chk(trace[w + 1].dataOe, 1'b0);
        runOp(cfgOf(1'b0, PORT_32, 4'h0, 4'h0), 32'h0000_9040, {1'b1, OP_WRITE});
        w = findCmd(SD_WRITE);
        chk(firstCmd(), SD_WRITE);
        chk(trace[w].memAddr, 13'h10);
        chk({trace[w + 3].dataOe, trace[w + 4].dataOe}, 2'h2);
        $display("test sdram write done");
    endtask
    task automatic testLoadRefresh();
        runOp(cfgOf(1'b0, PORT_32, 4'h0, 4'h0), 32'h0000_0230, {1'b0, OP_LOAD});
        chk(firstCmd(), SD_PRE);
        chk(trace[findCmd(SD_LMR)].memAddr, 13'h230);
        runOp(cfgOf(1'b0, PORT_32, 4'h0, 4'h0), 32'h0, {1'b0, OP_REFRESH});
        chk(firstCmd(), SD_REF);
        $display("test load and refresh done");
    endtask
    task automatic testFastPage();
        int last;
        runOp(cfgOf(1'b1, PORT_16, 4'h2, 4'h1), 32'h0000_500c, {1'b0, OP_READ});
        chk(cntCas(4'h3), 3);
        chk(trace.size() - cntCas(4'hf), 3);
        // beat wait kept nonzero for fast page bursts
        runOp(cfgOf(1'b1, PORT_8, 4'h2, 4'h1), 32'h0000_500c, {1'b1, OP_READ});
        chk(cntCas(4'h7), 9);
        chk(trace.size() - cntCas(4'hf), 9);
        // dma follows: at least thirteen idle entries after the last cas cycle
        runOp(cfgOf(1'b1, PORT_32, 4'h0, 4'h1) | (32'h1 << CFG_DMA_BIT), 32'h0000_500c,
              {1'b0, OP_READ});
        last = 0;
        foreach (trace[i]) if (trace[i].casN != 4'hf) last = i;
        chk(trace.size() - last > 13, 1'b1);
        for (int r = 0; r < 4; r++) begin
            runOp(cfgOf(1'b1, PORT_32, 4'h0, 4'h1) | (r << CFG_RLEN_LSB), 32'h0,
                  {1'b0, OP_REFRESH});
            chk(cntCas(4'h0), r + 2);
        end
        $display("test fast page done");
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 8'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        logOn = 1'b0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        testReset();
        testSdRead();
        testSdWrite();
        testLoadRefresh();
        testFastPage();
        conclude();
    end
endmodule
`default_nettype wire
